// file: ptm_peer_model.sv
/*
 * Peer peripherals of the period timer: drive the candidate reset sources and count output pulses.
 * Assumes clk and rst_b are shared with the timer and the bench commands the selected level.
 */
`default_nettype none

module ptm_peer_model
    import ptm_pkg::*;
#(
    parameter int SRC_W = 4,
    parameter int SRC_NUM = 16
) (
    input wire logic clk, // System clock.
    input wire logic rst_b, // Active-low reset.
    input wire logic [SRC_W-1:0] srcSelect, // Source the timer listens to.
    input wire logic trigLevel, // Commanded level of that source.
    input wire logic postscaledPulseOut, // Timer output pulse.
    output logic [SRC_NUM-1:0] externalResetSources, // Candidate reset signals.
    output var int pulseCount // Rising edges seen on the pulse.
);
    // ==========================================================
    // Unselected sources toggle every 16 cycles so a wrong pick shows up
    // ==========================================================
    logic [SRC_NUM-1:0] noise;
    logic pulseDly;

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            noise <= '0;
            pulseDly <= 1'b0;
            pulseCount <= 0;
        end else begin
            noise <= {noise[SRC_NUM-2:0], ~noise[SRC_NUM-1]};
            pulseDly <= postscaledPulseOut;
            if (postscaledPulseOut && !pulseDly) begin
                pulseCount <= pulseCount + 1;
            end
        end
    end

    // The bench only moves trigLevel with six timer clocks between edges.
    always_comb begin
        externalResetSources = noise;
        externalResetSources[srcSelect] = trigLevel;
    end
endmodule // ptm_peer_model

`default_nettype wire

// file: ptm_period_timer.sv
/*
 * 8-bit period timer with prescaler, postscaler, gate/reset/start modes.
 * Assumes all inputs are synchronous to clk; software writes arrive as
 * one-cycle strobes with data; the reset source vector comes from peers.
 */
// Function
// RQ1 - Count increments on each prescaler output tick while the gate is open and the timer runs.
// RQ2 - Count equal to period advances postscaler and returns count to zero.
// RQ3 - Prescaler divides by 1 to 128; postscaler divides by 1 to 16.
// RQ4 - Count and period are 8-bit, readable and writable by software.
// RQ5 - Reset clears count and loads period with all ones.
// RQ6 - Count write, control write, reset or external reset clear pre/postscaler.
// RQ7 - Control write leaves the count unchanged.
// RQ8 - Postscaler match gives a one timer-clock pulse, then clears postscaler.
// RQ9 - Gate modes hold the count while gate inactive, resume afterwards.
// RQ10 - Reset modes clear the count on the selected level or edge.
// RQ11 - One-shot match clears on bit and stops until on is cycled.
// RQ12 - One-shot ignores postscale selection; postscaler reset on restart.
// RQ13 - Monostable stops at match keeping on; external event restarts it.
// RQ14 - Postscaler match raises flag; enable bit gates it to the processor.
// RQ15 - Flag set on instruction clock; software clears it.
// RQ16 - Prescaler sync bit retimes prescaler output to instruction clock.
// RQ17 - Software sets prescaler sync only with a slow prescaler output.
// RQ18 - Control and status bits are timed by the instruction clock by default.
// RQ19 - Enable sync set: on bit retimed to the timer input clock.
// RQ20 - Enable sync clear: on bit retimed to the instruction clock.
// RQ21 - One external reset signal chosen by a source select starts/stops/resets.
// RQ22 - Five-bit mode: upper two bits class, lower three bits variant.
// RQ23 - External source spaces edges six and holds levels three timer clocks.
// RQ24 - Debug mode ignores all external trigger and reset inputs.
`default_nettype none

module ptm_period_timer
    import ptm_pkg::*;
#(
    parameter int RST_SRC_W = 4,
    parameter int RST_SRC_NUM = 16
) (
    input wire logic clk, // System clock.
    input wire logic rst_b, // Asynchronous active-low reset.
    input wire logic clkEn, // Freezes all state except the reset release synchronizer while low.
    input wire logic timerInputClock, // Selected timer input clock level.
    input wire logic [RST_SRC_NUM-1:0] externalResetSources, // Candidate reset signals.
    input wire logic [RST_SRC_W-1:0] resetSourceSelect, // Picks the external reset signal.
    input wire logic debugMode, // Processor in debug mode.
    input wire logic countWrite, // Strobe: load count.
    input wire logic [COUNT_W-1:0] countWriteData, // Count write data.
    input wire logic periodWrite, // Strobe: load period.
    input wire logic [COUNT_W-1:0] periodWriteData, // Period write data.
    input wire logic controlWrite, // Strobe: write timer control.
    input wire logic controlOn, // On bit value for a control write.
    input wire logic [PS_SEL_W-1:0] controlPrescale, // Prescale select, ratio 2**value.
    input wire logic [POST_W-1:0] controlPostscale, // Postscale select, ratio value+1.
    input wire logic [MODE_W-1:0] limitTimerMode, // Operating mode field.
    input wire logic prescalerSync, // Retime prescaler output to instruction clock.
    input wire logic enableSyncToTimerClock, // Retime on bit to timer input clock.
    input wire logic matchInterruptEnable, // Passes the flag to the processor.
    input wire logic flagClear, // Strobe: software clears the flag.
    output logic [COUNT_W-1:0] timerCount, // Current count.
    output logic [COUNT_W-1:0] periodValue, // Current period.
    output logic onBit, // Current on bit.
    output logic postscaledPulseOut, // One timer clock wide pulse.
    output logic interruptFlag, // Sticky match flag.
    output logic interruptRequest // Flag gated by the enable.
);

    // ==========================================================
    // Parameter checks
    // ==========================================================
    if (RST_SRC_W < 1 || RST_SRC_NUM < 1 || RST_SRC_NUM > (1 << RST_SRC_W)) begin : g_check
        $error("ptm_period_timer: reset source parameters out of range");
    end

    // ==========================================================
    // Reset release
    // ==========================================================
    logic [1:0] rstSync;
    logic rstLocal_b;

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            rstSync <= 2'h0;
        end else begin
            rstSync <= {rstSync[0], 1'b1};
        end
    end
    assign rstLocal_b = rstSync[1];

    // ==========================================================
    // State
    // ==========================================================
    typedef struct packed {
        logic [1:0] div;
        logic tclkPrev;
        logic [PRE_W-1:0] pre;
        logic pscPend;
        logic onBit;
        logic onEff;
        logic running;
        logic ersPrev;
        logic [COUNT_W-1:0] count;
        logic [COUNT_W-1:0] period;
        logic [POST_W-1:0] post;
        logic pulse;
        logic flagPend;
        logic flag;
        logic [PS_SEL_W-1:0] ps;
        logic [POST_W-1:0] postscale_select;
    } ptm_state_t;

    localparam ptm_state_t STATE_RST = '{
        div: 2'h0, tclkPrev: 1'b0, pre: PRE_RST, pscPend: 1'b0, onBit: 1'b0, onEff: 1'b0,
        running: 1'b0, ersPrev: 1'b0, count: COUNT_RST, period: PERIOD_RST, post: POST_RST,
        pulse: 1'b0, flagPend: 1'b0, flag: 1'b0, ps: PS_SEL_RST, postscale_select: POST_RST};

    ptm_state_t s;
    ptm_state_t next_s;

    // Returns {start edge, reset event, gate open} for the mode.
    function automatic logic [2:0] decodeMode(input logic [1:0] cls, input logic [2:0] sub,
                                              input logic ers, input logic rise, input logic fall);
        logic st;
        logic rs;
        logic gt;
        st = 1'b0;
        rs = 1'b0;
        gt = 1'b0;
        case (cls)
            CLASS_FREE: begin
                gt = 1'b1;
                case (sub)
                    SUB_GATE_HI: gt = ers;
                    SUB_GATE_LO: gt = ~ers;
                    SUB_ANY_RST: rs = rise | fall;
                    SUB_RISE_RST: rs = rise;
                    SUB_FALL_RST: rs = fall;
                    SUB_LOW_RST: rs = ~ers;
                    SUB_HIGH_RST: rs = ers;
                    default: gt = 1'b1;
                endcase
            end
            CLASS_ONESHOT: begin
                gt = 1'b1;
                case (sub)
                    SUB_GATE_HI: st = rise;
                    SUB_GATE_LO: st = fall;
                    SUB_ANY_RST: st = rise | fall;
                    SUB_RISE_RST: begin
                        st = rise;
                        rs = rise;
                    end
                    SUB_FALL_RST: begin
                        st = fall;
                        rs = fall;
                    end
                    SUB_LOW_RST: begin
                        st = rise;
                        rs = ~ers;
                    end
                    SUB_HIGH_RST: begin
                        st = fall;
                        rs = ers;
                    end
                    default: st = 1'b0;
                endcase
            end
            CLASS_MONO: begin
                gt = (sub != SUB_SOFT) && (sub <= SUB_ANY_RST);
                st = ((sub == SUB_GATE_HI) & rise) | ((sub == SUB_GATE_LO) & fall)
                   | ((sub == SUB_ANY_RST) & (rise | fall));
            end
            default: gt = 1'b0;
        endcase
        return {st, rs, gt};
    endfunction

    // ==========================================================
    // Next state
    // ==========================================================
    logic instrTick;
    logic timerEdge;
    logic ers;
    logic ersRise;
    logic ersFall;
    logic [1:0] modeClass;
    logic [2:0] modeSub;
    logic startEv;
    logic resetEv;
    logic gateOpen;
    logic needStart;
    logic pscOut;
    logic tickFinal;
    logic tick;
    logic match;
    logic postHit;
    logic [PRE_W-1:0] preLast;
    logic [POST_W-1:0] postSel;

    always_comb begin
        next_s = s;
        instrTick = (s.div == INSTR_LAST);
        next_s.div = s.div + INSTR_STEP;
        timerEdge = timerInputClock & ~s.tclkPrev;
        next_s.tclkPrev = timerInputClock;
        ers = debugMode ? s.ersPrev : externalResetSources[resetSourceSelect]; // [RQ21] [RQ24]
        next_s.ersPrev = ers;
        ersRise = ers & ~s.ersPrev;
        ersFall = ~ers & s.ersPrev;
        modeClass = limitTimerMode[MODE_CLASS_HI:MODE_CLASS_LO]; // [RQ22]
        modeSub = limitTimerMode[MODE_SUB_HI:0];
        {startEv, resetEv, gateOpen} = decodeMode(modeClass, modeSub, ers, ersRise, ersFall);
        needStart = (modeClass != CLASS_FREE) && (modeSub != SUB_SOFT);

        // Prescaler counts input edges while enabled.
        preLast = PRE_W'((8'h01 << s.ps) - 8'h01); // [RQ3]
        pscOut = timerEdge & s.onEff & (s.pre == preLast);
        if (timerEdge && s.onEff) begin
            next_s.pre = pscOut ? PRE_RST : s.pre + 7'h01;
        end
        if (prescalerSync) begin
            tickFinal = s.pscPend & instrTick; // [RQ16]
            next_s.pscPend = pscOut | (s.pscPend & ~instrTick);
        end else begin
            tickFinal = pscOut;
            next_s.pscPend = 1'b0;
        end

        // The on bit reaches the counter through one of two retiming points.
        if (enableSyncToTimerClock ? timerEdge : instrTick) begin
            next_s.onEff = s.onBit; // [RQ19] [RQ20]
        end

        if (needStart && !s.onEff) begin
            next_s.running = 1'b0;
        end else if (needStart && startEv) begin
            next_s.running = 1'b1; // [RQ13]
        end

        tick = tickFinal & s.onEff & gateOpen & (s.running | ~needStart); // [RQ1] [RQ9]
        match = (s.count == s.period);
        postSel = (modeClass == CLASS_ONESHOT) ? POST_RST : s.postscale_select; // [RQ12]
        postHit = tick & match & (s.post == postSel);

        if (timerEdge) begin
            next_s.pulse = 1'b0;
        end
        if (tick) begin
            if (match) begin
                next_s.count = COUNT_RST; // [RQ2]
                next_s.post = postHit ? POST_RST : s.post + 4'h1; // [RQ8]
                next_s.pulse = postHit;
                if (modeClass == CLASS_ONESHOT) begin
                    next_s.onBit = 1'b0; // [RQ11]
                    // Stops at once; the retimed enable would otherwise count one more edge.
                    next_s.onEff = 1'b0;
                    next_s.running = 1'b0;
                end else if (modeClass == CLASS_MONO) begin
                    next_s.running = 1'b0;
                end
            end else begin
                next_s.count = s.count + 8'h01; // [RQ1]
            end
        end

        // The flag is set on the instruction clock; a new set beats a clear.
        if (flagClear) begin
            next_s.flag = 1'b0; // [RQ15]
        end
        if (instrTick && s.flagPend) begin
            next_s.flag = 1'b1; // [RQ14] [RQ15] [RQ18]
            next_s.flagPend = 1'b0;
        end
        if (postHit) begin
            next_s.flagPend = 1'b1;
        end

        if (resetEv) begin
            next_s.count = COUNT_RST; // [RQ10]
            next_s.pre = PRE_RST; // [RQ6]
            next_s.post = POST_RST;
            next_s.pscPend = 1'b0;
        end
        if (periodWrite) begin
            next_s.period = periodWriteData; // [RQ4]
        end
        if (controlWrite) begin
            next_s.onBit = controlOn;
            next_s.ps = controlPrescale;
            next_s.postscale_select = controlPostscale;
            next_s.pre = PRE_RST; // [RQ6] [RQ7]
            next_s.post = POST_RST; // [RQ12]
            next_s.pscPend = 1'b0;
        end
        if (countWrite) begin
            next_s.count = countWriteData; // [RQ4]
            next_s.pre = PRE_RST; // [RQ6]
            next_s.post = POST_RST;
            next_s.pscPend = 1'b0;
        end
    end

    always_ff @(posedge clk or negedge rstLocal_b) begin
        if (!rstLocal_b) begin
            s <= STATE_RST; // [RQ5] [RQ6]
        end else if (clkEn) begin
            s <= next_s;
        end
    end

    // ==========================================================
    // Outputs
    // ==========================================================
    assign timerCount = s.count;
    assign periodValue = s.period;
    assign onBit = s.onBit;
    assign postscaledPulseOut = s.pulse;
    assign interruptFlag = s.flag;
    assign interruptRequest = s.flag & matchInterruptEnable; // [RQ14]

    // ==========================================================
    // Checks
    // ==========================================================
    logic quiet;
    assign quiet = ~countWrite & ~controlWrite & ~resetEv;

    chk_count_step: assert property (@(posedge clk) disable iff (!rstLocal_b || !clkEn) // [RQ1]
        tick && !match && quiet |=> s.count == $past(s.count) + 8'h01)
        else $error("count did not step on a tick");
    chk_match_wrap: assert property (@(posedge clk) disable iff (!rstLocal_b || !clkEn) // [RQ2]
        tick && match && quiet |=> s.count == COUNT_RST)
        else $error("count did not wrap on period match");
    chk_control_keeps: assert property (@(posedge clk) disable iff (!rstLocal_b || !clkEn) // [RQ7]
        controlWrite && !countWrite && !tick && !resetEv |=> s.count == $past(s.count) && s.pre == PRE_RST)
        else $error("control write disturbed the count");
    chk_write_clears: assert property (@(posedge clk) disable iff (!rstLocal_b || !clkEn) // [RQ6]
        countWrite |=> s.pre == PRE_RST && s.post == POST_RST && s.count == $past(countWriteData))
        else $error("count write did not clear the scalers");
    chk_pulse_holds: assert property (@(posedge clk) disable iff (!rstLocal_b || !clkEn) // [RQ8]
        s.pulse && !timerEdge |=> s.pulse)
        else $error("pulse ended before the next timer clock");
    chk_pulse_ends: assert property (@(posedge clk) disable iff (!rstLocal_b || !clkEn) // [RQ8]
        s.pulse && timerEdge && !postHit |=> !s.pulse)
        else $error("pulse outlasted one timer clock");
    chk_gate_hold: assert property (@(posedge clk) disable iff (!rstLocal_b || !clkEn) // [RQ9]
        !gateOpen && quiet |=> s.count == $past(s.count))
        else $error("count moved with the gate closed");
    chk_reset_clears: assert property (@(posedge clk) disable iff (!rstLocal_b || !clkEn) // [RQ10]
        resetEv && !countWrite |=> s.count == COUNT_RST)
        else $error("external reset did not clear the count");
    chk_oneshot_stop: assert property (@(posedge clk) disable iff (!rstLocal_b || !clkEn) // [RQ11]
        tick && match && modeClass == CLASS_ONESHOT && !controlWrite |=> !s.onBit)
        else $error("one-shot kept its on bit after match");
    chk_mono_keeps_on: assert property (@(posedge clk) disable iff (!rstLocal_b || !clkEn) // [RQ13]
        tick && match && modeClass == CLASS_MONO && !controlWrite |=> s.onBit && !s.running)
        else $error("monostable stop misbehaved");
    chk_flag_latency: assert property (@(posedge clk) disable iff (!rstLocal_b || !clkEn) // [RQ15]
        postHit && !flagClear |-> ##[1:5] s.flag)
        else $error("flag not set within an instruction clock");
    chk_debug_ignore: assert property (@(posedge clk) disable iff (!rstLocal_b || !clkEn) // [RQ24]
        debugMode |-> !ersRise && !ersFall)
        else $error("external edge seen in debug mode");

    cov_period_pulse: cover property (@(posedge clk) disable iff (!rstLocal_b) postHit && modeClass == CLASS_FREE);
    cov_oneshot_done: cover property (@(posedge clk) disable iff (!rstLocal_b) $fell(s.onBit) && !controlWrite);
    cov_mono_restart: cover property (@(posedge clk) disable iff (!rstLocal_b) modeClass == CLASS_MONO && $rose(s.running));
    cov_ext_reset: cover property (@(posedge clk) disable iff (!rstLocal_b) resetEv && s.count != COUNT_RST);

endmodule // ptm_period_timer

`default_nettype wire

// file: ptm_period_timer_bench.sv
/*
 * Self-checking bench of the period timer: free-run, prescale, gate, reset, one-shot and monostable.
 * Assumes the peer model file and the package are compiled first.
 */
`default_nettype none

module ptm_period_timer_bench;
    timeunit 1ns;
    timeprecision 1ps;
    import ptm_pkg::*;

    logic clk = 1'b0;
    logic rst_b = 1'b0;
    logic tic = 1'b0, trig = 1'b0, debugMode = 1'b0, flagClear = 1'b0;
    logic countWrite = 1'b0, periodWrite = 1'b0, controlWrite = 1'b0, controlOn = 1'b0;
    logic [7:0] wdata = 8'h00;
    logic [2:0] controlPrescale = 3'h0;
    logic [3:0] controlPostscale = 4'h0, srcSel = 4'h0;
    logic [4:0] mode = 5'h00;
    logic prescaler_sync = 1'b0, esync = 1'b0, mie = 1'b0, clkEn = 1'b1;
    logic [15:0] ers;
    logic [7:0] timerCount, periodValue;
    logic onBit, pulse, interruptFlag, interruptRequest;
    int pulseCount, miscompares = 0, tests_run = 0;
    int p, ps, sel, m, base, expPulses;

    ptm_period_timer i_ptm_period_timer (.clk(clk), .rst_b(rst_b), .clkEn(clkEn), .timerInputClock(tic),
        .externalResetSources(ers), .resetSourceSelect(srcSel), .debugMode(debugMode),
        .countWrite(countWrite), .countWriteData(wdata), .periodWrite(periodWrite), .periodWriteData(wdata),
        .controlWrite(controlWrite), .controlOn(controlOn), .controlPrescale(controlPrescale),
        .controlPostscale(controlPostscale), .limitTimerMode(mode), .prescalerSync(prescaler_sync),
        .enableSyncToTimerClock(esync), .matchInterruptEnable(mie), .flagClear(flagClear),
        .timerCount(timerCount), .periodValue(periodValue), .onBit(onBit), .postscaledPulseOut(pulse),
        .interruptFlag(interruptFlag), .interruptRequest(interruptRequest));

    ptm_peer_model i_ptm_peer_model (.clk(clk), .rst_b(rst_b), .srcSelect(srcSel), .trigLevel(trig),
        .postscaledPulseOut(pulse), .externalResetSources(ers), .pulseCount(pulseCount));

    initial begin
        forever #2 clk = ~clk;
    end

    // ==========================================================
    // Shared tasks
    // ==========================================================
    task automatic summarize();
        $display("checks %0d, mismatches %0d", tests_run, miscompares);
        if (miscompares == 0 && tests_run > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            miscompares++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic idle(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    // Ticks wrap after period+1; every (select+1)-th wrap gives a pulse.
    function automatic int expectCount(input int ticks, input int per);
        return ticks % (per + 1);
    endfunction

    function automatic int expectPulses(input int ticks, input int per, input int post);
        return (ticks / (per + 1)) / (post + 1);
    endfunction

    // Timer input clock period is eight system clocks, slower than the instruction clock.
    task automatic tick(input int n);
        repeat (n) begin
            @(posedge clk);
            tic <= 1'b1;
            repeat (4) @(posedge clk);
            tic <= 1'b0;
            repeat (3) @(posedge clk);
        end
    endtask

    // Kind 0 writes the count, 1 the period, 2 clears the flag.
    task automatic wr(input int kind, input logic [7:0] d);
        @(posedge clk);
        countWrite <= (kind == 0);
        periodWrite <= (kind == 1);
        flagClear <= (kind == 2);
        wdata <= d;
        @(posedge clk);
        countWrite <= 1'b0;
        periodWrite <= 1'b0;
        flagClear <= 1'b0;
        idle(3);
    endtask

    task automatic ctl(input logic on, input int pre, input int post);
        @(posedge clk);
        controlWrite <= 1'b1;
        controlOn <= on;
        controlPrescale <= pre[2:0];
        controlPostscale <= post[3:0];
        @(posedge clk);
        controlWrite <= 1'b0;
        idle(8);
    endtask

    // The first edge after enabling may be swallowed, so it is spent before the count is zeroed.
    task automatic setup(input logic [4:0] md, input int pre, input int post);
        @(posedge clk);
        mode <= md;
        ctl(1'b1, pre, post);
        tick(1);
        wr(0, 8'h00);
        idle(8);
        wr(2, 8'h00);
    endtask

    initial begin
        #400000;
        miscompares++;
        summarize();
    end

    // ==========================================================
    // Main sequence
    // ==========================================================
    initial begin
        void'($urandom(36334));
        repeat (16) @(posedge clk);
        rst_b <= 1'b1;
        idle(4);
        check("count", timerCount, 8'h00);
        check("period", periodValue, 8'hFF);
        check("on", onBit, 1'b0);
        check("flag", interruptFlag, 1'b0);
        @(posedge clk);
        srcSel <= 4'($urandom_range(0, 15));
        mie <= 1'($urandom_range(0, 1));
        wr(1, 8'h3C);
        check("period", periodValue, 8'h3C);
        wr(0, 8'h5A);
        check("count", timerCount, 8'h5A);
        ctl(1'b0, 3, 2);
        check("count", timerCount, 8'h5A);
        for (int it = 0; it < 3; it++) begin
            prescaler_sync <= it[0];
            esync <= (it != 0);
            p = (it == 1) ? 1 : $urandom_range(2, 9);
            ps = (it == 0) ? 7 : $urandom_range(0, 3);
            sel = (it == 1) ? 15 : $urandom_range(0, 3);
            m = (it == 0) ? $urandom_range(2, 5) : (it == 1) ? 34 : $urandom_range(5, 25);
            wr(1, 8'(p));
            setup(5'h00, ps, sel);
            base = pulseCount;
            tick(m << ps);
            idle(8);
            expPulses = expectPulses(m, p, sel);
            check("count", timerCount, expectCount(m, p));
            check("pulses", pulseCount - base, expPulses);
            if (expPulses > 0) begin
                check("flag", interruptFlag, 1'b1);
                check("request", interruptRequest, mie);
            end
            wr(2, 8'h00);
            check("flag", interruptFlag, 1'b0);
        end
        trig <= 1'b1;
        wr(1, 8'd20);
        setup(5'h01, 0, 0);
        tick(3);
        trig <= 1'b0;
        idle(48);
        tick(4);
        idle(8);
        check("gated count", timerCount, 8'd3);
        trig <= 1'b1;
        idle(48);
        tick(2);
        idle(8);
        check("gated count", timerCount, 8'd5);
        clkEn <= 1'b0;
        tick(2);
        clkEn <= 1'b1;
        idle(8);
        check("frozen count", timerCount, 8'd5);
        trig <= 1'b0;
        idle(48);
        setup(5'h04, 0, 0);
        tick(5);
        trig <= 1'b1;
        idle(48);
        check("reset count", timerCount, 8'd0);
        tick(3);
        debugMode <= 1'b1;
        idle(8);
        trig <= 1'b0;
        idle(48);
        trig <= 1'b1;
        idle(48);
        check("debug count", timerCount, 8'd3);
        debugMode <= 1'b0;
        setup(5'h08, 0, 5);
        base = pulseCount;
        tick(24);
        idle(8);
        check("oneshot on", onBit, 1'b0);
        check("oneshot count", timerCount, 8'd0);
        check("oneshot pulses", pulseCount - base, 1);
        setup(5'h08, 0, 5);
        tick(2);
        idle(8);
        check("restart count", timerCount, 8'd2);
        trig <= 1'b0;
        idle(48);
        setup(5'h11, 0, 0);
        trig <= 1'b1;
        idle(48);
        tick(23);
        idle(8);
        check("mono on", onBit, 1'b1);
        check("mono count", timerCount, 8'd0);
        trig <= 1'b0;
        idle(48);
        trig <= 1'b1;
        idle(48);
        tick(2);
        idle(8);
        check("mono restart", timerCount, 8'd2);
        rst_b <= 1'b0;
        idle(4);
        rst_b <= 1'b1;
        idle(4);
        check("reset count", timerCount, 8'h00);
        check("reset period", periodValue, 8'hFF);
        check("reset on", onBit, 1'b0);
        summarize();
    end
endmodule // ptm_period_timer_bench

`default_nettype wire

// file: ptm_pkg.sv
/*
 * Constants for the 8-bit period timer: widths, reset values, mode encodings
 * and the instruction-clock divider.
 * Assumes it is compiled before any module that imports it.
 */
`default_nettype none

package ptm_pkg;

    // ==========================================================
    // Widths
    // ==========================================================
    localparam int COUNT_W = 8;
    localparam int PRE_W = 7;
    localparam int PS_SEL_W = 3;
    localparam int POST_W = 4;
    localparam int MODE_W = 5;

    // ==========================================================
    // Reset values
    // ==========================================================
    localparam logic [COUNT_W-1:0] COUNT_RST = 8'h00;
    localparam logic [COUNT_W-1:0] PERIOD_RST = 8'hFF;
    localparam logic [PRE_W-1:0] PRE_RST = 7'h00;
    localparam logic [POST_W-1:0] POST_RST = 4'h0;
    localparam logic [PS_SEL_W-1:0] PS_SEL_RST = 3'h0;

    // ==========================================================
    // Mode field layout and encodings
    // ==========================================================
    localparam int MODE_CLASS_HI = 4;
    localparam int MODE_CLASS_LO = 3;
    localparam int MODE_SUB_HI = 2;
    localparam logic [1:0] CLASS_FREE = 2'h0;
    localparam logic [1:0] CLASS_ONESHOT = 2'h1;
    localparam logic [1:0] CLASS_MONO = 2'h2;
    localparam logic [2:0] SUB_SOFT = 3'h0;
    localparam logic [2:0] SUB_GATE_HI = 3'h1;
    localparam logic [2:0] SUB_GATE_LO = 3'h2;
    localparam logic [2:0] SUB_ANY_RST = 3'h3;
    localparam logic [2:0] SUB_RISE_RST = 3'h4;
    localparam logic [2:0] SUB_FALL_RST = 3'h5;
    localparam logic [2:0] SUB_LOW_RST = 3'h6;
    localparam logic [2:0] SUB_HIGH_RST = 3'h7;

    // ==========================================================
    // Instruction clock is the system clock divided by four
    // ==========================================================
    localparam logic [1:0] INSTR_LAST = 2'h3;
    localparam logic [1:0] INSTR_STEP = 2'h1;

endpackage : ptm_pkg

`default_nettype wire
